// ==== design/mmf_motion_front.sv ====
// operating mode front end: torque, step/direction and auto setup
// assumes object access strobes and pins synchronous to ref_clk
// Summary of operation
// - mode object value 10 selects cyclic synchronous torque
// - torque mode drives nothing unless closed loop is active
// - status bit 8 shows fieldbus sync
// - in torque mode status bit 12 shows the target preset is used
// - torque limited to the smaller of max current and max torque
// - cycle is period value times one millisecond; only index -3 exists
// - torque offset in tenths of a percent added to the set value
// - no ramps; each preset followed directly
// - mode object value FFh selects step/direction operation
// - each step pulse moves demand one scaled step in the given sense
// - pulses collected during a cycle applied once per cycle
// - step per pulse is numerator over denominator, default 128/1
// - status bit 13 flags following error beyond window past timeout
// - submode 0: step input pulses, direction input level gives sense
// - submode 1: one pulse input per sense
// - mode object value FEh selects auto setup
// - setup travel starts on a rising edge of control bit 4 only
// - status bit 10 shows an encoder index was found during setup
// - status bit 12 set when setup completes; closed loop needs it
`timescale 1ns/1ps
`include "mmf_cfg.svh"
module mmf_motion_front
   import mmf_pkg::*;
#(
   parameter int BASE_CYCLES = `MMF_BASE_CYCLES,
   parameter int ACC_W       = 20
) (
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   input  wire logic               clkEn,
   input  wire logic               objWrEn,
   input  wire logic               objRdEn,
   input  wire logic [15:0]        objIndex,
   input  wire logic [7:0]         objSub,
   input  wire logic [31:0]        objWrData,
   input  wire logic               stepIn,
   input  wire logic               dirIn,
   input  wire logic               closedLoopOn,
   input  wire logic               busSynced,
   input  wire logic               encIndexSeen,
   input  wire logic               setupTravelDone,
   input  wire logic               followErrOutside,
   input  wire logic [15:0]        followTimeoutMs,
   output logic [31:0]             objRdData,
   output logic                    objRdValid,
   output logic [15:0]             statusWord,
   output logic signed [15:0]      torqueDemand,
   output logic signed [31:0]      demandPos,
   output logic                    cycleTick,
   output logic                    setupStart,
   output logic                    closedLoopAllowed
);
   // object storage
   logic [31:0]        stepNum_r,   stepNum_nxt;
   logic [31:0]        stepDen_r,   stepDen_nxt;
   logic [31:0]        subMode_r,   subMode_nxt;
   logic [15:0]        ctrl_r,      ctrl_nxt;
   logic [7:0]         mode_r,      mode_nxt;
   logic [15:0]        trqTgt_r,    trqTgt_nxt;
   logic [15:0]        trqMax_r,    trqMax_nxt;
   logic [15:0]        curMax_r,    curMax_nxt;
   logic [31:0]        speedMax_r,  speedMax_nxt;
   logic [15:0]        trqOff_r,    trqOff_nxt;
   logic [7:0]         period_r,    period_nxt;
   // timing, pulse and status state
   logic [15:0]        baseCnt_r,   baseCnt_nxt;
   logic [7:0]         cycCnt_r,    cycCnt_nxt;
   logic               stepPrev_r,  stepPrev_nxt;
   logic               dirPrev_r,   dirPrev_nxt;
   logic signed [ACC_W-1:0] acc_r,  acc_nxt;
   logic signed [31:0] total_r,     total_nxt;
   logic [15:0]        ferrCnt_r,   ferrCnt_nxt;
   logic               ferr_r,      ferr_nxt;
   logic               indexed_r,   indexed_nxt;
   logic               aligned_r,   aligned_nxt;
   mmf_setup_e         setup_r,     setup_nxt;
   logic [31:0]        rdData_r,    rdData_nxt;
   logic               rdValid_r,   rdValid_nxt;
   logic [15:0]        status_r,    status_nxt;
   mmf_torque_t        trqDem_r,    trqDem_nxt;
   logic signed [31:0] pos_r,       pos_nxt;
   logic               tick_r,      tick_nxt;
   logic               start_r,     start_nxt;
   logic               clAllow_r,   clAllow_nxt;

   logic                    baseTick;
   logic                    cycEnd;
   logic                    torqueMode;
   logic                    stepMode;
   logic                    setupMode;
   logic                    loopOk;
   logic signed [ACC_W-1:0] stepInc;
   logic signed [31:0]      newTotal;
   logic signed [63:0]      scaledProd;
   logic signed [63:0]      scaledPos;
   logic [15:0]             limRaw;
   logic signed [16:0]      lim;
   logic signed [16:0]      trqSum;
   logic signed [16:0]      trqSat;

   assign torqueMode = (mode_r == `MMF_MODE_TORQUE);
   assign stepMode   = (mode_r == `MMF_MODE_STEP);
   assign setupMode  = (mode_r == `MMF_MODE_SETUP);
   // closed loop only counts once setup has aligned the sensors
   assign loopOk     = closedLoopOn & aligned_r;
   assign baseTick   = (baseCnt_r == 16'(BASE_CYCLES - 1));
   // a zero period would stall the cycle, so it behaves as one
   assign cycEnd     = baseTick & ((cycCnt_r + 8'h01 >= period_r) | (period_r == 8'h00));

   always_comb begin
      stepInc = '0;
      if (stepMode) begin
         if (subMode_r == `MMF_SUBMODE_DUAL_PULSE) begin
            if (stepIn & ~stepPrev_r & ~(dirIn & ~dirPrev_r)) begin
               stepInc = ACC_W'(1);
            end else if (dirIn & ~dirPrev_r & ~(stepIn & ~stepPrev_r)) begin
               stepInc = -ACC_W'(1);
            end
         end else if (stepIn & ~stepPrev_r) begin
            stepInc = dirIn ? -ACC_W'(1) : ACC_W'(1);
         end
      end
   end

   assign newTotal   = total_r + 32'(acc_r);
   assign scaledProd = 64'(newTotal) * $signed({32'h0, stepNum_r});
   assign scaledPos  = (stepDen_r == 32'h0) ? 64'(pos_r) : scaledProd / $signed({32'h0, stepDen_r});
   // limit kept positive and within the signed demand range
   assign limRaw     = (curMax_r < trqMax_r) ? curMax_r : trqMax_r;
   assign lim        = limRaw[15] ? 17'sh07FFF : $signed({1'b0, limRaw});
   assign trqSum     = $signed({trqTgt_r[15], trqTgt_r}) + $signed({trqOff_r[15], trqOff_r});
   always_comb begin
      if (trqSum > lim) begin
         trqSat = lim;
      end else if (trqSum < -lim) begin
         trqSat = -lim;
      end else begin
         trqSat = trqSum;
      end
   end

   always_comb begin
      stepNum_nxt  = stepNum_r;
      stepDen_nxt  = stepDen_r;
      subMode_nxt  = subMode_r;
      ctrl_nxt     = ctrl_r;
      mode_nxt     = mode_r;
      trqTgt_nxt   = trqTgt_r;
      trqMax_nxt   = trqMax_r;
      curMax_nxt   = curMax_r;
      speedMax_nxt = speedMax_r;
      trqOff_nxt   = trqOff_r;
      period_nxt   = period_r;
      if (objWrEn) begin
         if (objIndex == `MMF_IDX_STEP_NUM) begin
            stepNum_nxt = objWrData;
         end else if (objIndex == `MMF_IDX_STEP_DEN) begin
            stepDen_nxt = objWrData;
         end else if (objIndex == `MMF_IDX_SUBMODE) begin
            subMode_nxt = objWrData;
         end else if (objIndex == `MMF_IDX_CTRL) begin
            ctrl_nxt = objWrData[15:0];
         end else if (objIndex == `MMF_IDX_MODE) begin
            mode_nxt = objWrData[7:0];
         end else if (objIndex == `MMF_IDX_TRQ_TARGET) begin
            trqTgt_nxt = objWrData[15:0];
         end else if (objIndex == `MMF_IDX_TRQ_MAX) begin
            trqMax_nxt = objWrData[15:0];
         end else if (objIndex == `MMF_IDX_CUR_MAX) begin
            curMax_nxt = objWrData[15:0];
         end else if (objIndex == `MMF_IDX_SPEED_MAX) begin
            speedMax_nxt = objWrData;
         end else if (objIndex == `MMF_IDX_TRQ_OFFSET) begin
            trqOff_nxt = objWrData[15:0];
         end else if (objIndex == `MMF_IDX_CYCLE && objSub == `MMF_SUB_PERIOD) begin
            period_nxt = objWrData[7:0];
         end
      end
   end

   always_comb begin
      baseCnt_nxt  = baseTick ? 16'h0000 : baseCnt_r + 16'h0001;
      cycCnt_nxt   = cycCnt_r;
      if (cycEnd) begin
         cycCnt_nxt = 8'h00;
      end else if (baseTick) begin
         cycCnt_nxt = cycCnt_r + 8'h01;
      end
      stepPrev_nxt = stepIn;
      dirPrev_nxt  = dirIn;
      total_nxt    = total_r;
      pos_nxt      = pos_r;
      // a pulse in the closing cycle opens the next count, none is lost
      if (cycEnd) begin
         total_nxt = newTotal;
         pos_nxt   = scaledPos[31:0];
         acc_nxt   = stepInc;
      end else begin
         acc_nxt   = acc_r + stepInc;
      end
      if (!stepMode) begin
         acc_nxt = '0;
      end
      trqDem_nxt = trqDem_r;
      if (!(torqueMode && loopOk)) begin
         trqDem_nxt = 16'sh0000;
      end else if (cycEnd) begin
         trqDem_nxt = trqSat[15:0];
      end
      tick_nxt = cycEnd;
   end

   always_comb begin
      ferrCnt_nxt = ferrCnt_r;
      ferr_nxt    = ferr_r;
      if (!(stepMode && loopOk) || !followErrOutside) begin
         ferrCnt_nxt = 16'h0000;
         ferr_nxt    = 1'b0;
      end else if (ferrCnt_r > followTimeoutMs) begin
         ferr_nxt = 1'b1;
      end else if (baseTick) begin
         ferrCnt_nxt = ferrCnt_r + 16'h0001;
      end
      setup_nxt   = setup_r;
      start_nxt   = 1'b0;
      indexed_nxt = indexed_r;
      aligned_nxt = aligned_r;
      case (setup_r)
         MMF_SETUP_IDLE, MMF_SETUP_DONE: begin
            if (setupMode && objWrEn && objIndex == `MMF_IDX_CTRL &&
                objWrData[`MMF_CTRL_START_BIT] && !ctrl_r[`MMF_CTRL_START_BIT]) begin
               setup_nxt   = MMF_SETUP_RUN;
               start_nxt   = 1'b1;
               indexed_nxt = 1'b0;
               aligned_nxt = 1'b0;
            end
         end
         MMF_SETUP_RUN: begin
            if (encIndexSeen) begin
               indexed_nxt = 1'b1;
            end
            if (setupTravelDone) begin
               aligned_nxt = 1'b1;
               setup_nxt   = MMF_SETUP_DONE;
            end
         end
         default: begin
            setup_nxt = MMF_SETUP_IDLE;
         end
      endcase
      clAllow_nxt = aligned_nxt;
   end

   always_comb begin
      status_nxt = 16'h0000;
      status_nxt[`MMF_ST_SYNC_BIT] = busSynced;
      if (torqueMode) begin
         status_nxt[`MMF_ST_FOLLOW_BIT] = loopOk;
      end else if (stepMode) begin
         status_nxt[`MMF_ST_FERR_BIT] = ferr_r;
      end else if (setupMode) begin
         status_nxt[`MMF_ST_INDEX_BIT]  = indexed_r;
         status_nxt[`MMF_ST_FOLLOW_BIT] = aligned_r;
      end
      rdValid_nxt = objRdEn;
      rdData_nxt  = rdData_r;
      if (objRdEn) begin
         if (objIndex == `MMF_IDX_STEP_NUM) begin
            rdData_nxt = stepNum_r;
         end else if (objIndex == `MMF_IDX_STEP_DEN) begin
            rdData_nxt = stepDen_r;
         end else if (objIndex == `MMF_IDX_SUBMODE) begin
            rdData_nxt = subMode_r;
         end else if (objIndex == `MMF_IDX_CTRL) begin
            rdData_nxt = {16'h0000, ctrl_r};
         end else if (objIndex == `MMF_IDX_STATUS) begin
            rdData_nxt = {16'h0000, status_r};
         end else if (objIndex == `MMF_IDX_MODE) begin
            rdData_nxt = {24'h000000, mode_r};
         end else if (objIndex == `MMF_IDX_TRQ_TARGET) begin
            rdData_nxt = {16'h0000, trqTgt_r};
         end else if (objIndex == `MMF_IDX_TRQ_MAX) begin
            rdData_nxt = {16'h0000, trqMax_r};
         end else if (objIndex == `MMF_IDX_CUR_MAX) begin
            rdData_nxt = {16'h0000, curMax_r};
         end else if (objIndex == `MMF_IDX_TRQ_DEMAND) begin
            rdData_nxt = {16'h0000, trqDem_r};
         end else if (objIndex == `MMF_IDX_SPEED_MAX) begin
            rdData_nxt = speedMax_r;
         end else if (objIndex == `MMF_IDX_TRQ_OFFSET) begin
            rdData_nxt = {16'h0000, trqOff_r};
         end else if (objIndex == `MMF_IDX_CYCLE && objSub == `MMF_SUB_PERIOD) begin
            rdData_nxt = {24'h000000, period_r};
         end else if (objIndex == `MMF_IDX_CYCLE && objSub == `MMF_SUB_TIME_INDEX) begin
            rdData_nxt = {24'h000000, `MMF_TIME_INDEX_MS};
         end else begin
            rdData_nxt = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stepNum_r  <= `MMF_RST_STEP_NUM;
         stepDen_r  <= `MMF_RST_STEP_DEN;
         subMode_r  <= `MMF_RST_SUBMODE;
         ctrl_r     <= `MMF_RST_CTRL;
         mode_r     <= `MMF_RST_MODE;
         trqTgt_r   <= `MMF_RST_TRQ;
         trqMax_r   <= `MMF_RST_TRQ;
         curMax_r   <= `MMF_RST_TRQ;
         speedMax_r <= `MMF_RST_SPEED;
         trqOff_r   <= `MMF_RST_TRQ;
         period_r   <= `MMF_RST_PERIOD;
         baseCnt_r  <= 16'h0000;
         cycCnt_r   <= 8'h00;
         stepPrev_r <= 1'b0;
         dirPrev_r  <= 1'b0;
         acc_r      <= '0;
         total_r    <= 32'sh0000_0000;
         ferrCnt_r  <= 16'h0000;
         ferr_r     <= 1'b0;
         indexed_r  <= 1'b0;
         aligned_r  <= 1'b0;
         setup_r    <= MMF_SETUP_IDLE;
         rdData_r   <= 32'h0000_0000;
         rdValid_r  <= 1'b0;
         status_r   <= 16'h0000;
         trqDem_r   <= 16'sh0000;
         pos_r      <= 32'sh0000_0000;
         tick_r     <= 1'b0;
         start_r    <= 1'b0;
         clAllow_r  <= 1'b0;
      end else if (clkEn) begin
         stepNum_r  <= stepNum_nxt;
         stepDen_r  <= stepDen_nxt;
         subMode_r  <= subMode_nxt;
         ctrl_r     <= ctrl_nxt;
         mode_r     <= mode_nxt;
         trqTgt_r   <= trqTgt_nxt;
         trqMax_r   <= trqMax_nxt;
         curMax_r   <= curMax_nxt;
         speedMax_r <= speedMax_nxt;
         trqOff_r   <= trqOff_nxt;
         period_r   <= period_nxt;
         baseCnt_r  <= baseCnt_nxt;
         cycCnt_r   <= cycCnt_nxt;
         stepPrev_r <= stepPrev_nxt;
         dirPrev_r  <= dirPrev_nxt;
         acc_r      <= acc_nxt;
         total_r    <= total_nxt;
         ferrCnt_r  <= ferrCnt_nxt;
         ferr_r     <= ferr_nxt;
         indexed_r  <= indexed_nxt;
         aligned_r  <= aligned_nxt;
         setup_r    <= setup_nxt;
         rdData_r   <= rdData_nxt;
         rdValid_r  <= rdValid_nxt;
         status_r   <= status_nxt;
         trqDem_r   <= trqDem_nxt;
         pos_r      <= pos_nxt;
         tick_r     <= tick_nxt;
         start_r    <= start_nxt;
         clAllow_r  <= clAllow_nxt;
      end
   end

   assign objRdData         = rdData_r;
   assign objRdValid        = rdValid_r;
   assign statusWord        = status_r;
   assign torqueDemand      = trqDem_r;
   assign demandPos         = pos_r;
   assign cycleTick         = tick_r;
   assign setupStart        = start_r;
   assign closedLoopAllowed = clAllow_r;
endmodule : mmf_motion_front

// ==== inc/mmf_cfg.svh ====
// object indices, field positions, reset values and timing counts of the mode front end
// included by the design; holds definitions only
`ifndef MMF_CFG_SVH
`define MMF_CFG_SVH
`define MMF_IDX_STEP_NUM     16'h2057
`define MMF_IDX_STEP_DEN     16'h2058
`define MMF_IDX_SUBMODE      16'h205B
`define MMF_IDX_CTRL         16'h6040
`define MMF_IDX_STATUS       16'h6041
`define MMF_IDX_MODE         16'h6060
`define MMF_IDX_TRQ_TARGET   16'h6071
`define MMF_IDX_TRQ_MAX      16'h6072
`define MMF_IDX_CUR_MAX      16'h6073
`define MMF_IDX_TRQ_DEMAND   16'h6074
`define MMF_IDX_SPEED_MAX    16'h6080
`define MMF_IDX_TRQ_OFFSET   16'h60B2
`define MMF_IDX_CYCLE        16'h60C2
`define MMF_SUB_PERIOD       8'h01
`define MMF_SUB_TIME_INDEX   8'h02
`define MMF_RST_STEP_NUM     32'h0000_0080
`define MMF_RST_STEP_DEN     32'h0000_0001
`define MMF_RST_SUBMODE      32'h0000_0000
`define MMF_RST_CTRL         16'h0000
`define MMF_RST_MODE         8'h00
`define MMF_RST_TRQ          16'h0000
`define MMF_RST_SPEED        32'h0000_0000
`define MMF_RST_PERIOD       8'h01
`define MMF_TIME_INDEX_MS    8'hFD
`define MMF_MODE_TORQUE      8'h0A
`define MMF_MODE_STEP        8'hFF
`define MMF_MODE_SETUP       8'hFE
`define MMF_SUBMODE_PULSE_SENSE 32'h0000_0000
`define MMF_SUBMODE_DUAL_PULSE  32'h0000_0001
`define MMF_CTRL_START_BIT   4
`define MMF_ST_SYNC_BIT      8
`define MMF_ST_INDEX_BIT     10
`define MMF_ST_FOLLOW_BIT    12
`define MMF_ST_FERR_BIT      13
`define MMF_CLK_PERIOD_NS    100
`define MMF_BASE_TIME_NS     1000000
`define MMF_BASE_CYCLES      (`MMF_BASE_TIME_NS / `MMF_CLK_PERIOD_NS)
`endif

// ==== inc/mmf_pkg.sv ====
// types shared by the mode front end
// constants live in mmf_cfg.svh
package mmf_pkg;
   typedef enum logic [1:0] {
      MMF_SETUP_IDLE = 2'b00,
      MMF_SETUP_RUN  = 2'b01,
      MMF_SETUP_DONE = 2'b10
   } mmf_setup_e;
   typedef logic signed [15:0] mmf_torque_t;
endpackage : mmf_pkg

// ==== sim/mmf_motion_front_bench.sv ====
// self-checking bench for the operating mode front end
// millisecond shortened to 10 clocks; pulse source model drives the pins
`timescale 1ns/1ps
module mmf_motion_front_bench;
   localparam int BASE  = 10;
   localparam int LIMIT = 20000;
   logic               ref_clk, rst_b, clkEn, objWrEn, objRdEn, stepIn, dirIn;
   logic               closedLoopOn, busSynced, encIndexSeen, setupTravelDone, followErrOutside;
   logic [15:0]        objIndex, followTimeoutMs, statusWord;
   logic [7:0]         objSub;
   logic [31:0]        objWrData, objRdData;
   logic               objRdValid, cycleTick, setupStart, closedLoopAllowed;
   logic signed [15:0] torqueDemand;
   logic signed [31:0] demandPos;
   int                 n_mismatch, n_compared, cycles;

   mmf_motion_front #(.BASE_CYCLES(BASE)) i_mmf_motion_front (
      .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .objWrEn(objWrEn), .objRdEn(objRdEn),
      .objIndex(objIndex), .objSub(objSub), .objWrData(objWrData), .stepIn(stepIn), .dirIn(dirIn),
      .closedLoopOn(closedLoopOn), .busSynced(busSynced), .encIndexSeen(encIndexSeen),
      .setupTravelDone(setupTravelDone), .followErrOutside(followErrOutside),
      .followTimeoutMs(followTimeoutMs), .objRdData(objRdData), .objRdValid(objRdValid),
      .statusWord(statusWord), .torqueDemand(torqueDemand), .demandPos(demandPos),
      .cycleTick(cycleTick), .setupStart(setupStart), .closedLoopAllowed(closedLoopAllowed));
   mmf_pulse_source i_mmf_pulse_source (.ref_clk(ref_clk), .stepIn(stepIn), .dirIn(dirIn));

   always #50 ref_clk = ~ref_clk;

   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // a hang costs a mismatch instead of a stuck run
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data);
      @(negedge ref_clk);
      objWrEn = 1'b1;
      objIndex = idx;
      objSub = sub;
      objWrData = data;
      @(negedge ref_clk);
      objWrEn = 1'b0;
   endtask : wr

   // answer registered at the taking edge, seen at the next falling edge
   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
      @(negedge ref_clk);
      objRdEn = 1'b1;
      objIndex = idx;
      objSub = sub;
      @(negedge ref_clk);
      objRdEn = 1'b0;
      chk({31'h0, objRdValid}, 32'h0000_0001);
      chk(objRdData, exp);
   endtask : rd

   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge ref_clk);
         while (cycleTick !== 1'b1) @(negedge ref_clk);
      end
   endtask : ticks

   task automatic t_regs;
      rd(16'h2057, 8'h00, 32'h0000_0080);
      rd(16'h2058, 8'h00, 32'h0000_0001);
      rd(16'h205B, 8'h00, 32'h0000_0000);
      rd(16'h60C2, 8'h01, 32'h0000_0001);
      wr(16'h6074, 8'h00, 32'h0000_1234);
      rd(16'h6074, 8'h00, 32'h0000_0000);
      rd(16'h1234, 8'h00, 32'h0000_0000);
      $display("test regs finished");
   endtask : t_regs

   task automatic t_setup;
      wr(16'h6060, 8'h00, 32'h0000_00FE);
      wr(16'h6040, 8'h00, 32'h0000_0010);
      chk({31'h0, setupStart}, 32'h0000_0001);
      encIndexSeen = 1'b1;
      @(negedge ref_clk);
      encIndexSeen = 1'b0;
      setupTravelDone = 1'b1;
      @(negedge ref_clk);
      setupTravelDone = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({16'h0, statusWord & 16'h1400}, 32'h0000_1400);
      chk({31'h0, closedLoopAllowed}, 32'h0000_0001);
      wr(16'h6040, 8'h00, 32'h0000_0010);
      chk({31'h0, setupStart}, 32'h0000_0000);
      wr(16'h6040, 8'h00, 32'h0000_0000);
      $display("test setup finished");
   endtask : t_setup

   task automatic t_torque;
      logic [15:0] tgt [4];
      logic [15:0] exp [4];
      tgt = '{16'h01C2, 16'h02BC, 16'hFC7C, 16'h01C2};
      exp = '{16'h0226, 16'h0258, 16'hFDA8, 16'h01F4};
      closedLoopOn = 1'b1;
      wr(16'h6072, 8'h00, 32'h0000_03E8);
      wr(16'h6073, 8'h00, 32'h0000_0258);
      wr(16'h60B2, 8'h00, 32'h0000_0064);
      wr(16'h6060, 8'h00, 32'h0000_000A);
      for (int i = 0; i < 4; i++) begin
         if (i == 3) wr(16'h6072, 8'h00, 32'h0000_01F4);
         wr(16'h6071, 8'h00, {16'h0, tgt[i]});
         ticks(2);
         chk({16'h0, torqueDemand}, {16'h0, exp[i]});
         chk({31'h0, statusWord[12]}, 32'h0000_0001);
      end
      closedLoopOn = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk({16'h0, torqueDemand}, 32'h0000_0000);
      chk({31'h0, statusWord[12]}, 32'h0000_0000);
      closedLoopOn = 1'b1;
      $display("test torque finished");
   endtask : t_torque

   task automatic t_step;
      int gap;
      wr(16'h60C2, 8'h01, 32'h0000_000A);
      wr(16'h60C2, 8'h02, 32'h0000_0001);
      rd(16'h60C2, 8'h02, 32'h0000_00FD);
      ticks(1);
      gap = 0;
      do begin
         @(negedge ref_clk);
         gap++;
      end while (cycleTick !== 1'b1);
      chk(gap, 32'h0000_0064);
      wr(16'h6060, 8'h00, 32'h0000_00FF);
      i_mmf_pulse_source.send(7, 1'b0, 1'b0);
      ticks(2);
      chk(demandPos, 32'h0000_0380);
      i_mmf_pulse_source.send(3, 1'b1, 1'b0);
      ticks(2);
      chk(demandPos, 32'h0000_0200);
      wr(16'h2057, 8'h00, 32'h0000_0200);
      wr(16'h2058, 8'h00, 32'h0000_0002);
      ticks(2);
      chk(demandPos, 32'h0000_0400);
      wr(16'h205B, 8'h00, 32'h0000_0001);
      i_mmf_pulse_source.send(5, 1'b0, 1'b1);
      i_mmf_pulse_source.send(2, 1'b1, 1'b1);
      ticks(2);
      chk(demandPos, 32'h0000_0700);
      $display("test step finished");
   endtask : t_step

   task automatic t_ferr;
      wr(16'h60C2, 8'h01, 32'h0000_0001);
      followTimeoutMs = 16'h0002;
      followErrOutside = 1'b1;
      repeat (2 * BASE) @(negedge ref_clk);
      chk({31'h0, statusWord[13]}, 32'h0000_0000);
      repeat (3 * BASE) @(negedge ref_clk);
      chk({31'h0, statusWord[13]}, 32'h0000_0001);
      followErrOutside = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk({31'h0, statusWord[13]}, 32'h0000_0000);
      chk({31'h0, statusWord[8]}, 32'h0000_0000);
      busSynced = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({31'h0, statusWord[8]}, 32'h0000_0001);
      rd(16'h6041, 8'h00, 32'h0000_0100);
      $display("test following error finished");
   endtask : t_ferr

   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      clkEn = 1'b1;
      objWrEn = 1'b0;
      objRdEn = 1'b0;
      objIndex = 16'h0000;
      objSub = 8'h00;
      objWrData = 32'h0000_0000;
      closedLoopOn = 1'b0;
      busSynced = 1'b0;
      encIndexSeen = 1'b0;
      setupTravelDone = 1'b0;
      followErrOutside = 1'b0;
      followTimeoutMs = 16'h0000;
      n_mismatch = 0;
      n_compared = 0;
      repeat (4) @(negedge ref_clk);
      rst_b = 1'b1;
      t_regs();
      t_setup();
      t_torque();
      t_step();
      t_ferr();
      conclude();
   end
endmodule : mmf_motion_front_bench

// ==== sim/mmf_motion_front_properties.sv ====
// concurrent checks on the ports of the mode front end
// bound to mmf_motion_front; assumes clkEn held high by the bench
`timescale 1ns/1ps
module mmf_motion_front_properties #(
   parameter int BASE_CYCLES = 10
) (
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   input  wire logic               clkEn,
   input  wire logic               objWrEn,
   input  wire logic               objRdEn,
   input  wire logic [15:0]        objIndex,
   input  wire logic [7:0]         objSub,
   input  wire logic [31:0]        objWrData,
   input  wire logic               busSynced,
   input  wire logic               closedLoopOn,
   input  wire logic               setupTravelDone,
   input  wire logic               followErrOutside,
   input  wire logic [31:0]        objRdData,
   input  wire logic               objRdValid,
   input  wire logic [15:0]        statusWord,
   input  wire logic signed [15:0] torqueDemand,
   input  wire logic signed [31:0] demandPos,
   input  wire logic               cycleTick,
   input  wire logic               setupStart,
   input  wire logic               closedLoopAllowed
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // clocks since the last cycle tick
   int sinceTick_r;
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b) sinceTick_r <= BASE_CYCLES;
      else if (clkEn) sinceTick_r <= cycleTick ? 1 : sinceTick_r + 1;
   a_tick_spacing: assert property (cycleTick |-> sinceTick_r >= BASE_CYCLES)
      else $error("cycle tick earlier than one millisecond");
   a_index_readback: assert property (clkEn && objRdEn && objIndex == 16'h60C2 && objSub == 8'h02
      |=> objRdValid && objRdData == 32'h0000_00FD) else $error("time index read wrong");
   a_sync_follows: assert property ($stable(busSynced) |=> statusWord[8] == $past(busSynced))
      else $error("sync bit does not follow input");
   a_torque_gated: assert property (!closedLoopOn |=> torqueDemand == 16'sh0000)
      else $error("torque driven without closed loop");
   a_pos_on_tick: assert property (!cycleTick |-> $stable(demandPos))
      else $error("demand position moved between cycles");
   a_start_cause: assert property (setupStart |->
      $past(objWrEn && objIndex == 16'h6040 && objWrData[4]) ##1 !setupStart) else $error("setup start without cause");
   a_aligned_cause: assert property ($rose(closedLoopAllowed) |->
      $past(setupTravelDone, 1) || $past(setupTravelDone, 2)) else $error("aligned without setup done");
   a_ferr_cause: assert property (statusWord[13] |-> closedLoopAllowed &&
      ($past(followErrOutside, 1) || $past(followErrOutside, 2))) else $error("following error flag without cause");
endmodule : mmf_motion_front_properties

bind mmf_motion_front mmf_motion_front_properties #(.BASE_CYCLES(BASE_CYCLES)) i_mmf_motion_front_properties (
   .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .objWrEn(objWrEn), .objRdEn(objRdEn),
   .objIndex(objIndex), .objSub(objSub), .objWrData(objWrData), .busSynced(busSynced),
   .closedLoopOn(closedLoopOn), .setupTravelDone(setupTravelDone), .followErrOutside(followErrOutside),
   .objRdData(objRdData), .objRdValid(objRdValid), .statusWord(statusWord), .torqueDemand(torqueDemand),
   .demandPos(demandPos), .cycleTick(cycleTick), .setupStart(setupStart), .closedLoopAllowed(closedLoopAllowed));

// ==== sim/mmf_pulse_source.sv ====
// step/direction pulse source standing in for the positioning controller
// drives its lines after falling edges of ref_clk; the bench calls send()
`timescale 1ns/1ps
module mmf_pulse_source #(
   parameter int HALF_CYC   = 5,
   parameter int DIR_SETTLE = 350
) (
   input  wire logic ref_clk,
   output logic      stepIn,
   output logic      dirIn
);
   initial begin
      stepIn = 1'b0;
      dirIn = 1'b0;
   end
   // dual: a negative train pulses dirIn instead of stepIn
   task automatic send(input int n, input logic neg, input logic dual);
      if (dual && dirIn) begin
         @(negedge ref_clk) dirIn = 1'b0;
         repeat (HALF_CYC) @(negedge ref_clk);
      end
      if (!dual && dirIn !== neg) begin
         @(negedge ref_clk) dirIn = neg;
         repeat (DIR_SETTLE) @(negedge ref_clk);
      end
      repeat (n) begin
         @(negedge ref_clk);
         if (dual && neg) dirIn = 1'b1;
         else stepIn = 1'b1;
         repeat (HALF_CYC) @(negedge ref_clk);
         stepIn = 1'b0;
         if (dual) dirIn = 1'b0;
         repeat (HALF_CYC - 1) @(negedge ref_clk);
      end
   endtask : send
endmodule : mmf_pulse_source
